/* File: test/tcic_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external capture pin
// ----------------------------------------
module tcic_pin_model (
	input wire logic clk,
	output logic pin
);
	initial pin = 1'b0;
	// n pulses, hi cycles high then lo cycles low, moved just after a rising edge
	task automatic pulses(input int n, input int hi, input int lo);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (hi) @(posedge clk);
			pin <= 1'b0;
			repeat (lo - 1) @(posedge clk);
		end
	endtask : pulses
endmodule : tcic_pin_model
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// capture control bench
// ----------------------------------------
module testbench
	import tcic_pkg::*;
;
	logic clk, rstn, read, write, pin, waitrequest, chACapture, chBCapture;
	logic [3:0] address, byteenable;
	logic [31:0] writedata, readdata, rd, ctrl;
	logic [2:0] chAIoSelect, chBIoSelect;
	logic [4:0] route;
	int src = 0, badCount = 0, nCompared = 0, cycles = 0, capA = 0, capB = 0, a0, b0;
	int r [0:7];
	// channel, io select, filter, divider, source, pulses, high cycles, captures
	int rows [0:25][0:7] = '{
		'{0,1,0,0,0,3,4,3}, '{0,1,0,1,0,5,4,2}, '{0,1,0,2,0,9,4,2}, '{0,1,0,3,0,8,4,1},
		'{0,1,1,0,0,3,1,0}, '{0,1,1,0,0,2,3,2}, '{0,1,3,0,0,2,6,0}, '{0,1,3,0,0,2,12,2},
		'{0,1,5,0,0,1,12,0}, '{0,1,5,0,0,1,24,1}, '{0,1,7,0,0,1,24,0}, '{0,1,7,0,0,1,48,1},
		'{0,1,10,0,0,1,60,0}, '{0,1,10,0,0,1,120,1}, '{0,1,15,0,0,1,200,0},
		'{0,1,15,0,0,1,320,1}, '{1,1,0,1,1,4,4,2}, '{1,1,3,0,1,2,6,0}, '{0,2,0,0,1,2,4,2},
		'{1,2,0,0,0,2,4,2}, '{0,3,0,0,2,2,4,2}, '{0,4,0,0,3,2,4,2}, '{1,4,0,0,4,2,4,2},
		'{0,0,0,0,0,2,4,0}, '{0,5,0,0,0,2,4,0}, '{0,7,0,0,0,2,4,0}
	};
	// pin feeds the chosen source only
	assign route = pin ? (5'h01 << src) : 5'h00;
	tcic_pin_model i_pinModel (.clk(clk), .pin(pin));
	tcic_capture_ctrl i_dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .chARawInput(route[0]), .chBRawInput(route[1]),
		.chAMultiInput(route[3]), .chBMultiInput(route[4]), .triggerInput(route[2]),
		.chACapture(chACapture), .chBCapture(chBCapture), .chAFiltered(),
		.chBFiltered(), .chAIoSelect(chAIoSelect), .chBIoSelect(chBIoSelect));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// capture pulse counts and hang limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (chACapture === 1'b1) capA <= capA + 1;
		if (chBCapture === 1'b1) capB <= capB + 1;
		if (cycles == 20000) begin
			badCount++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	initial begin
		rstn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0000_0000;
		byteenable = 4'hF;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		// table of pulse trains per configuration
		foreach (rows[i]) begin
			r = rows[i];
			ctrl = (r[2] << (4 + 8 * r[0])) | (r[3] << (2 + 8 * r[0]));
			ctrl = ctrl | ((r[1] & 3) << (8 * r[0])) | ((r[1] >> 2) << (30 + r[0]));
			bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0000);
			bus(1'b1, TCIC_CTRL_OFFSET, ctrl);
			bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0001 << r[0]);
			src = r[4];
			a0 = capA;
			b0 = capB;
			i_pinModel.pulses(r[5], r[6], r[6]);
			repeat (r[6] + 12) @(posedge clk);
			check(r[0] ? capB - b0 : capA - a0, r[7]);
			check(r[0] ? capA - a0 : capB - b0, 0);
			$display("row %0d done", i);
		end
		// reserved bits and split io select fields
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0000);
		bus(1'b1, TCIC_CTRL_OFFSET, 32'hFFFF_FFFF);
		bus(1'b0, TCIC_CTRL_OFFSET, 32'h0000_0000);
		check(rd, 32'hC000_FFFF);
		check({chAIoSelect, chBIoSelect}, 6'h3F);
		// io select held while the channel or its used partner is on
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0001);
		bus(1'b1, TCIC_CTRL_OFFSET, 32'h0000_0000);
		bus(1'b0, TCIC_CTRL_OFFSET, 32'h0000_0000);
		check(rd, 32'h4000_0003);
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0014);
		bus(1'b1, TCIC_CTRL_OFFSET, 32'h0000_0000);
		bus(1'b0, TCIC_CTRL_OFFSET, 32'h0000_0000);
		check(chAIoSelect, 3'h7);
		bus(1'b0, 4'hC, 32'h0000_0000);
		check(rd, TCIC_READ_IDLE);
		$display("register layout done");
		// divider count dropped when the channel is switched off
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0000);
		bus(1'b1, TCIC_CTRL_OFFSET, 32'h0000_0005);
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0001);
		src = 0;
		a0 = capA;
		i_pinModel.pulses(1, 4, 4);
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0000);
		bus(1'b1, TCIC_ENABLE_OFFSET, 32'h0000_0001);
		i_pinModel.pulses(1, 4, 4);
		repeat (16) @(posedge clk);
		check(capA - a0, 0);
		i_pinModel.pulses(1, 4, 4);
		repeat (16) @(posedge clk);
		check(capA - a0, 1);
		// status: filtered levels low with the pin idle, counts track the seen pulses
		bus(1'b0, TCIC_STATUS_OFFSET, 32'h0000_0000);
		check(rd, {8'h00, capB[7:0], capA[7:0], 8'h00});
		$display("divider clear done");
		// second reset in mid-run
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		check({waitrequest, chAIoSelect}, 4'h8);
		bus(1'b0, TCIC_CTRL_OFFSET, 32'h0000_0000);
		check(rd, TCIC_CTRL_RESET);
		bus(1'b0, TCIC_ENABLE_OFFSET, 32'h0000_0000);
		check(rd, {26'h0, TCIC_ENABLE_RESET});
		$display("reset done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire

/* File: verilog/tcic_capture_ctrl.sv */
// Contract
// - Channel A's input filter setting is the 4-bit field at bits 7:4 of the control register.
// - The raw input is sampled at the chosen rate and runs of equal samples are counted.
// - A new level is accepted only once the run of equal samples reaches the chosen count.
// - Setting 0 disables the filter; 1..3 need 2/4/8 kernel samples; 4/5 need 6/8 at dts/2.
// - Channel A's edge divider is the 2-bit field at bits 3:2 and sets edges per capture.
// - Divider 00 gives a capture on every qualified edge.
// - Dividers 01, 10 and 11 give one capture per 2, 4 and 8 qualified edges.
// - Channel A's edge divider count clears whenever channel A's enable is low.
// - Channel B has its filter at bits 15:12 and divider at bits 11:10, working alike.
// - Channel A's 3-bit io select has its top bit at bit 30 and low bits at 1:0.
// - Channel B's 3-bit io select has its top bit at bit 31 and low bits at 9:8.
// - Io select codes: output, own input, neighbour input, trigger, multi-mode input.
// - An io select write is taken only while the channel and any used partner are off.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tcic_capture_ctrl
	import tcic_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [TCIC_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic chARawInput,
	input wire logic chBRawInput,
	input wire logic chAMultiInput,
	input wire logic chBMultiInput,
	input wire logic triggerInput,
	output logic chACapture,
	output logic chBCapture,
	output logic chAFiltered,
	output logic chBFiltered,
	output logic [2:0] chAIoSelect,
	output logic [2:0] chBIoSelect
);

	logic [31:0] ctrl_reg;
	logic [5:0] enable_reg;
	logic [7:0] capCntA_reg;
	logic [7:0] capCntB_reg;
	logic waitReg;
	logic [1:0] syncA_reg;
	logic [1:0] syncB_reg;
	logic [TCIC_DTS_DIV_W-1:0] dtsCnt_reg;
	logic [TCIC_RATE_N-1:0] rateTick;
	logic srcAPrev_reg;
	logic srcBPrev_reg;
	logic srcA;
	logic srcB;
	logic edgeA;
	logic edgeB;
	logic busReq;
	logic busTake;
	logic ctrlWrite;
	logic enableWrite;
	logic modeOpenA;
	logic modeOpenB;
	logic [31:0] ctrlMerged;
	logic [31:0] ctrl_next;
	logic [31:0] enableMerged;
	logic [31:0] readValue;
	tcic_chcfg_s cfgA;
	tcic_chcfg_s cfgB;
	logic chAEnable;
	logic chBEnable;

	// ----------------------------------------------------------------
	// byte lane merge, used for each writable register
	// ----------------------------------------------------------------
	function automatic logic [31:0] tcic_merge(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] lanes);
		logic [31:0] r;
		r = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (lanes[b]) begin
				r[b*8 +: 8] = newVal[b*8 +: 8];
			end
		end
		return r;
	endfunction : tcic_merge

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, then the access completes
	// ----------------------------------------------------------------
	assign busReq = read || write;
	assign busTake = busReq && !waitReg;
	assign ctrlWrite = busTake && write && (address == TCIC_CTRL_OFFSET);
	assign enableWrite = busTake && write && (address == TCIC_ENABLE_OFFSET);

	// waitrequest drops for the cycle after a request appears
	always_ff @(posedge clk) begin
		if (!rstn) begin
			waitReg <= 1'b1;
		end else begin
			waitReg <= !(busReq && waitReg);
		end
	end
	assign waitrequest = waitReg;

	// read value, unmapped addresses read zero
	always_comb begin
		readValue = TCIC_READ_IDLE;
		unique case (address)
			TCIC_CTRL_OFFSET: readValue = ctrl_reg;
			TCIC_ENABLE_OFFSET: readValue[5:0] = enable_reg;
			TCIC_STATUS_OFFSET: begin
				readValue[TCIC_ST_FILT_A_POS] = chAFiltered;
				readValue[TCIC_ST_FILT_B_POS] = chBFiltered;
				readValue[TCIC_ST_CNT_A_POS +: 8] = capCntA_reg;
				readValue[TCIC_ST_CNT_B_POS +: 8] = capCntB_reg;
			end
			default: readValue = TCIC_READ_IDLE;
		endcase
	end

	// read data stand in the cycle where waitrequest is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			readdata <= TCIC_READ_IDLE;
		end else if (read && waitReg) begin
			readdata <= readValue;
		end
	end

	// ----------------------------------------------------------------
	// channel control register
	// ----------------------------------------------------------------
	assign chAEnable = enable_reg[TCIC_EN_A_POS];
	assign chBEnable = enable_reg[TCIC_EN_B_POS];
	// io select is locked while the channel or its used partner runs
	assign modeOpenA = !chAEnable &&
		!(enable_reg[TCIC_EN_A_MULTI_POS] && enable_reg[TCIC_EN_A_PARTNER_POS]);
	assign modeOpenB = !chBEnable &&
		!(enable_reg[TCIC_EN_B_MULTI_POS] && enable_reg[TCIC_EN_B_PARTNER_POS]);
	assign ctrlMerged = tcic_merge(ctrl_reg, writedata, byteenable);

	// next control value with locked fields kept and reserved fields cleared to zero
	always_comb begin
		ctrl_next = ctrlMerged;
		ctrl_next[TCIC_RSVD_HI_POS:TCIC_RSVD_LO_POS] = 14'h0000;
		if (!modeOpenA) begin
			ctrl_next[TCIC_A_SEL_HI_POS] = ctrl_reg[TCIC_A_SEL_HI_POS];
			ctrl_next[TCIC_A_SEL_LO_POS +: 2] = ctrl_reg[TCIC_A_SEL_LO_POS +: 2];
		end
		if (!modeOpenB) begin
			ctrl_next[TCIC_B_SEL_HI_POS] = ctrl_reg[TCIC_B_SEL_HI_POS];
			ctrl_next[TCIC_B_SEL_LO_POS +: 2] = ctrl_reg[TCIC_B_SEL_LO_POS +: 2];
		end
	end

	// control register storage
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_reg <= TCIC_CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// enable register storage
	assign enableMerged = tcic_merge({26'h000_0000, enable_reg}, writedata, byteenable);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			enable_reg <= TCIC_ENABLE_RESET;
		end else if (enableWrite) begin
			enable_reg <= enableMerged[5:0];
		end
	end

	// field unpacking of the control register
	assign cfgA.ioSelect = {ctrl_reg[TCIC_A_SEL_HI_POS], ctrl_reg[TCIC_A_SEL_LO_POS +: 2]};
	assign cfgA.filterSel = ctrl_reg[TCIC_A_FILT_POS +: 4];
	assign cfgA.edgeDivider = ctrl_reg[TCIC_A_DIV_POS +: 2];
	assign cfgB.ioSelect = {ctrl_reg[TCIC_B_SEL_HI_POS], ctrl_reg[TCIC_B_SEL_LO_POS +: 2]};
	assign cfgB.filterSel = ctrl_reg[TCIC_B_FILT_POS +: 4];
	assign cfgB.edgeDivider = ctrl_reg[TCIC_B_DIV_POS +: 2];
	assign chAIoSelect = cfgA.ioSelect;
	assign chBIoSelect = cfgB.ioSelect;

	// ----------------------------------------------------------------
	// sampling strobes from the dead-time divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dtsCnt_reg <= '0;
		end else begin
			dtsCnt_reg <= dtsCnt_reg + 5'h01;
		end
	end

	assign rateTick[0] = 1'b1; // kernel clock rate
	for (genvar k = 1; k < TCIC_RATE_N; k++) begin : g_rate
		assign rateTick[k] = &dtsCnt_reg[k-1:0];
	end

	// ----------------------------------------------------------------
	// input synchronisers and digital filters
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			syncA_reg <= 2'b00;
			syncB_reg <= 2'b00;
		end else begin
			syncA_reg <= {syncA_reg[0], chARawInput};
			syncB_reg <= {syncB_reg[0], chBRawInput};
		end
	end

	tcic_input_filter u_filter_a (
		.clk(clk),
		.rstn(rstn),
		.sampleIn(syncA_reg[1]),
		.filterSel(cfgA.filterSel),
		.rateTick(rateTick),
		.filteredLevel(chAFiltered)
	);

	tcic_input_filter u_filter_b (
		.clk(clk),
		.rstn(rstn),
		.sampleIn(syncB_reg[1]),
		.filterSel(cfgB.filterSel),
		.rateTick(rateTick),
		.filteredLevel(chBFiltered)
	);

	// ----------------------------------------------------------------
	// capture source selection and rising edge detect
	// ----------------------------------------------------------------
	function automatic logic tcic_pick_source(input logic [2:0] sel, input logic own,
		input logic neighbour, input logic trig, input logic multi);
		logic s;
		s = 1'b0;
		case (sel)
			TCIC_IO_OWN: s = own;
			TCIC_IO_NEIGHBOUR: s = neighbour;
			TCIC_IO_TRIGGER: s = trig;
			TCIC_IO_MULTI: s = multi;
			default: s = 1'b0; // output and reserved codes capture nothing
		endcase
		return s;
	endfunction : tcic_pick_source

	assign srcA = tcic_pick_source(cfgA.ioSelect, chAFiltered, chBFiltered,
		triggerInput, chAMultiInput);
	assign srcB = tcic_pick_source(cfgB.ioSelect, chBFiltered, chAFiltered,
		triggerInput, chBMultiInput);

	// previous source level for edge detect
	always_ff @(posedge clk) begin
		if (!rstn) begin
			srcAPrev_reg <= 1'b0;
			srcBPrev_reg <= 1'b0;
		end else begin
			srcAPrev_reg <= srcA;
			srcBPrev_reg <= srcB;
		end
	end
	assign edgeA = srcA && !srcAPrev_reg;
	assign edgeB = srcB && !srcBPrev_reg;

	// ----------------------------------------------------------------
	// edge dividers and capture counters
	// ----------------------------------------------------------------
	tcic_edge_divider u_div_a (
		.clk(clk),
		.rstn(rstn),
		.chEnable(chAEnable),
		.edgeIn(edgeA),
		.edgeDivider(cfgA.edgeDivider),
		.capturePulse(chACapture)
	);

	tcic_edge_divider u_div_b (
		.clk(clk),
		.rstn(rstn),
		.chEnable(chBEnable),
		.edgeIn(edgeB),
		.edgeDivider(cfgB.edgeDivider),
		.capturePulse(chBCapture)
	);

	// capture event counts shown in the status register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			capCntA_reg <= TCIC_COUNT_RESET;
			capCntB_reg <= TCIC_COUNT_RESET;
		end else begin
			capCntA_reg <= capCntA_reg + {7'h00, chACapture};
			capCntB_reg <= capCntB_reg + {7'h00, chBCapture};
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking ccb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_BUS_ONE_WAIT: assert property (
		(busReq && waitReg) |=> !waitReg ##1 waitReg)
		else $error("waitrequest not low for exactly one cycle");
	AST_RSVD_ZERO: assert property (
		ctrlWrite |=> ctrl_reg[29:16] == 14'h0000)
		else $error("reserved control bits were written");
	AST_MODE_LOCK_A: assert property (
		(ctrlWrite && !modeOpenA) |=> $stable({ctrl_reg[30], ctrl_reg[1:0]}))
		else $error("channel A io select changed while locked");
	AST_MODE_TAKE_B: assert property (
		(ctrlWrite && modeOpenB && byteenable == 4'hF) |=>
		chBIoSelect == {$past(writedata[31]), $past(writedata[9:8])})
		else $error("channel B io select not taken from bits 31 and 9:8");
	AST_FIELD_A: assert property (
		(ctrlWrite && byteenable[0]) |=>
		cfgA.filterSel == $past(writedata[7:4]) && cfgA.edgeDivider == $past(writedata[3:2]))
		else $error("channel A filter or divider field misplaced");
	COV_CAPTURE_A: cover property (chAEnable ##1 chACapture);
	COV_MODE_REFUSED: cover property (ctrlWrite && !modeOpenB);

endmodule : tcic_capture_ctrl
`default_nettype wire

/* File: verilog/tcic_edge_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module tcic_edge_divider
	import tcic_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic chEnable,
	input wire logic edgeIn,
	input wire logic [1:0] edgeDivider,
	output logic capturePulse
);

	logic [2:0] edgeCnt_reg;
	logic [2:0] limit;

	// ----------------------------------------------------------------
	// one capture per 1, 2, 4 or 8 qualified edges
	// ----------------------------------------------------------------
	assign limit = 3'((4'h1 << edgeDivider) - 4'h1);

	// edge counter, cleared while the channel is disabled
	always_ff @(posedge clk) begin
		if (!rstn || !chEnable) begin
			edgeCnt_reg <= 3'h0;
		end else if (edgeIn) begin
			edgeCnt_reg <= (edgeCnt_reg >= limit) ? 3'h0 : edgeCnt_reg + 3'h1;
		end
	end

	// capture strobe on the edge that completes a group
	always_ff @(posedge clk) begin
		if (!rstn) begin
			capturePulse <= 1'b0;
		end else begin
			capturePulse <= chEnable && edgeIn && (edgeCnt_reg >= limit);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_DIV_CLEAR: assert property (
		!chEnable |=> (edgeCnt_reg == 3'h0) && !capturePulse)
		else $error("edge divider not cleared while disabled");
	AST_DIV_BYPASS: assert property (
		(chEnable && edgeIn && edgeDivider == 2'b00) |=> capturePulse)
		else $error("undivided edge gave no capture");
	AST_DIV_EIGHT: assert property (
		(chEnable && edgeIn && edgeDivider == 2'b11 && edgeCnt_reg != 3'h7) |=> !capturePulse)
		else $error("divide by eight captured early");
	AST_DIV_NO_EDGE: assert property (
		!edgeIn |=> !capturePulse)
		else $error("capture without a qualified edge");
	COV_DIV_FOUR: cover property (
		(edgeDivider == 2'b10) ##1 capturePulse);

endmodule : tcic_edge_divider
`default_nettype wire

/* File: verilog/tcic_input_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module tcic_input_filter
	import tcic_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic sampleIn,
	input wire logic [3:0] filterSel,
	input wire logic [TCIC_RATE_N-1:0] rateTick,
	output logic filteredLevel
);

	tcic_filt_s cfg;
	logic sampleNow;
	logic prevSample_reg;
	logic [3:0] sameCnt_reg;
	logic [3:0] sameCnt_next;

	// ----------------------------------------------------------------
	// sample strobe and run length
	// ----------------------------------------------------------------
	assign cfg = tcic_decode_filter(filterSel);
	assign sampleNow = rateTick[cfg.rate];
	// restart at one when the level differs, saturate at eight
	assign sameCnt_next = (sampleIn != prevSample_reg) ? 4'h1 :
		((sameCnt_reg == 4'h8) ? 4'h8 : sameCnt_reg + 4'h1);

	// sample history and count of equal samples
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prevSample_reg <= 1'b0;
			sameCnt_reg <= 4'h0;
		end else if (cfg.bypass) begin
			prevSample_reg <= sampleIn;
			sameCnt_reg <= 4'h0;
		end else if (sampleNow) begin
			prevSample_reg <= sampleIn;
			sameCnt_reg <= sameCnt_next;
		end
	end

	// output level moves only after the required run
	always_ff @(posedge clk) begin
		if (!rstn) begin
			filteredLevel <= 1'b0;
		end else if (cfg.bypass) begin
			filteredLevel <= sampleIn;
		end else if (sampleNow && sameCnt_next >= cfg.need) begin
			filteredLevel <= sampleIn;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking fcb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_FILT_BYPASS: assert property (
		cfg.bypass |=> filteredLevel == $past(sampleIn))
		else $error("bypassed filter did not follow its input");
	AST_FILT_HOLD_NO_SAMPLE: assert property (
		(!cfg.bypass && !sampleNow) |=> $stable(filteredLevel))
		else $error("filtered level moved without a sample");
	AST_FILT_SHORT_RUN: assert property (
		(!cfg.bypass && sampleNow && sameCnt_next < cfg.need) |=> $stable(filteredLevel))
		else $error("filtered level moved before the run was long enough");
	AST_FILT_RESTART: assert property (
		(!cfg.bypass && sampleNow && sampleIn != prevSample_reg) |=> sameCnt_reg == 4'h1)
		else $error("run counter did not restart on a level change");
	COV_FILT_SLOW_CHANGE: cover property (
		(filterSel == 4'hF) ##1 $changed(filteredLevel));

endmodule : tcic_input_filter
`default_nettype wire

/* File: verilog/tcic_pkg.sv */
package tcic_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int TCIC_ADDR_W = 4;
	localparam logic [3:0] TCIC_CTRL_OFFSET = 4'h0;
	localparam logic [3:0] TCIC_ENABLE_OFFSET = 4'h4;
	localparam logic [3:0] TCIC_STATUS_OFFSET = 4'h8;

	localparam logic [31:0] TCIC_CTRL_RESET = 32'h0000_0000;
	localparam logic [5:0] TCIC_ENABLE_RESET = 6'h00;
	localparam logic [7:0] TCIC_COUNT_RESET = 8'h00;
	localparam logic [31:0] TCIC_READ_IDLE = 32'h0000_0000;

	// ----------------------------------------------------------------
	// channel control register fields
	// ----------------------------------------------------------------
	localparam int TCIC_A_SEL_LO_POS = 0;    // io select [1:0]
	localparam int TCIC_A_DIV_POS = 2;       // edge divider [1:0]
	localparam int TCIC_A_FILT_POS = 4;      // input filter [3:0]
	localparam int TCIC_B_SEL_LO_POS = 8;
	localparam int TCIC_B_DIV_POS = 10;
	localparam int TCIC_B_FILT_POS = 12;
	localparam int TCIC_RSVD_LO_POS = 16;    // bits 29:16 reserved
	localparam int TCIC_RSVD_HI_POS = 29;
	localparam int TCIC_A_SEL_HI_POS = 30;   // io select [2]
	localparam int TCIC_B_SEL_HI_POS = 31;

	// ----------------------------------------------------------------
	// enable register fields
	// ----------------------------------------------------------------
	localparam int TCIC_EN_A_POS = 0;
	localparam int TCIC_EN_B_POS = 1;
	localparam int TCIC_EN_A_PARTNER_POS = 2;
	localparam int TCIC_EN_B_PARTNER_POS = 3;
	localparam int TCIC_EN_A_MULTI_POS = 4;
	localparam int TCIC_EN_B_MULTI_POS = 5;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int TCIC_ST_FILT_A_POS = 0;
	localparam int TCIC_ST_FILT_B_POS = 1;
	localparam int TCIC_ST_CNT_A_POS = 8;
	localparam int TCIC_ST_CNT_B_POS = 16;

	// ----------------------------------------------------------------
	// sampling rates: index 0 kernel clock, k = dead-time clock / 2^k
	// ----------------------------------------------------------------
	localparam int TCIC_RATE_N = 6;
	localparam int TCIC_DTS_DIV_W = 5;

	typedef enum logic [2:0] {
		TCIC_IO_OUTPUT = 3'h0,
		TCIC_IO_OWN = 3'h1,
		TCIC_IO_NEIGHBOUR = 3'h2,
		TCIC_IO_TRIGGER = 3'h3,
		TCIC_IO_MULTI = 3'h4
	} tcic_io_e;

	typedef struct packed {
		logic [2:0] ioSelect;
		logic [3:0] filterSel;
		logic [1:0] edgeDivider;
	} tcic_chcfg_s;

	typedef struct packed {
		logic bypass;
		logic [2:0] rate;
		logic [3:0] need;
	} tcic_filt_s;

	// filter setting to sampling rate and consecutive sample count
	function automatic tcic_filt_s tcic_decode_filter(input logic [3:0] sel);
		tcic_filt_s f;
		f.bypass = 1'b0;
		unique case (sel)
			4'h0: begin f.bypass = 1'b1; f.rate = 3'h0; f.need = 4'h1; end
			4'h1: begin f.rate = 3'h0; f.need = 4'h2; end
			4'h2: begin f.rate = 3'h0; f.need = 4'h4; end
			4'h3: begin f.rate = 3'h0; f.need = 4'h8; end
			4'h4: begin f.rate = 3'h1; f.need = 4'h6; end
			4'h5: begin f.rate = 3'h1; f.need = 4'h8; end
			4'h6: begin f.rate = 3'h2; f.need = 4'h6; end
			4'h7: begin f.rate = 3'h2; f.need = 4'h8; end
			4'h8: begin f.rate = 3'h3; f.need = 4'h6; end
			4'h9: begin f.rate = 3'h3; f.need = 4'h8; end
			4'hA: begin f.rate = 3'h4; f.need = 4'h5; end
			4'hB: begin f.rate = 3'h4; f.need = 4'h6; end
			4'hC: begin f.rate = 3'h4; f.need = 4'h8; end
			4'hD: begin f.rate = 3'h5; f.need = 4'h5; end
			4'hE: begin f.rate = 3'h5; f.need = 4'h6; end
			4'hF: begin f.rate = 3'h5; f.need = 4'h8; end
		endcase
		return f;
	endfunction : tcic_decode_filter

endpackage : tcic_pkg
